/* File: shared/poc_defs.svh */
// Address map, control word fields and reset values of the interrupt control block.
`ifndef POC_DEFS_SVH
`define POC_DEFS_SVH

// ==========================================================
// Port addresses
`define POC_ADDR_MASTER_CMD 16'h0020
`define POC_ADDR_SLAVE_CMD 16'h00a0
`define POC_ADDR_MASTER_TRIG 16'h04d0
`define POC_ADDR_SLAVE_TRIG 16'h04d1

// ==========================================================
// Control word fields
`define POC_SEL_MSB 4
`define POC_SEL_LSB 3
`define POC_SEL_WORD_THREE 2'h1
`define POC_SEL_WORD_TWO 2'h0
`define POC_BIT_MASK_MODE 6
`define POC_BIT_MASK_MODE_WE 5
`define POC_BIT_POLL 2
`define POC_BIT_RR 1
`define POC_BIT_RIS 0
`define POC_POLL_VALID 7

// ==========================================================
// Trigger register write masks and reset values
`define POC_MASTER_TRIG_WMASK 8'hf8
`define POC_SLAVE_TRIG_WMASK 8'hde
`define POC_TRIG_RESET 8'h00
`define POC_RDATA_IDLE 8'h00

`endif

/* File: shared/poc_pkg.sv */
// Types shared by the interrupt control block.
package poc_pkg;

  // ==========================================================
  // Status readback selection
  typedef enum logic {
    POC_READ_PENDING,
    POC_READ_IN_SERVICE
  } poc_rsel_e;

  typedef logic [7:0] poc_byte_t;

endpackage

/* File: src/poc_ctrl.sv */
// Third control word decode, status readback, poll and trigger mode registers.
`timescale 1ns/1ps
`include "poc_defs.svh"

// ==========================================================

module poc_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [15:0] irq_in,
  input wire logic [15:0] in_service_levels,
  input wire logic [15:0] mask_in,
  input wire logic [15:0] pending_clear,
  input wire logic [1:0] init_done,
  output logic [7:0] io_rdata,
  output logic [15:0] pending_requests,
  output logic [7:0] master_trigger_mode,
  output logic [7:0] slave_trigger_mode,
  output logic [1:0] special_masking_mode,
  output logic [1:0] op_control_word_two_wr,
  output logic [1:0] poll_ack,
  output logic [5:0] poll_level
);

  // ==========================================================
  // Priority pick
  // Fixed order, level 0 highest; rotation belongs to the priority logic outside.
  function automatic logic [3:0] poll_pick(input logic [7:0] req, input logic [7:0] msk,
                                           input logic [7:0] isv, input logic mask_mode);
    logic [3:0] res;
    logic stop;
    res = 4'h0;
    stop = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!stop && !mask_mode && isv[i]) begin
        stop = 1'b1;
      end else if (!stop && req[i] && !msk[i]) begin
        res = {1'b1, 3'(i)};
        stop = 1'b1;
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Address decode
  logic [1:0] wr_cmd;
  logic [1:0] rd_cmd;
  logic [1:0] sel_field;
  logic wr_mtrig;
  logic wr_strig;
  logic rd_mtrig;
  logic rd_strig;

  assign wr_cmd[0] = io_wr && (io_addr == `POC_ADDR_MASTER_CMD);
  assign wr_cmd[1] = io_wr && (io_addr == `POC_ADDR_SLAVE_CMD);
  assign rd_cmd[0] = io_rd && (io_addr == `POC_ADDR_MASTER_CMD);
  assign rd_cmd[1] = io_rd && (io_addr == `POC_ADDR_SLAVE_CMD);
  assign sel_field = io_wdata[`POC_SEL_MSB:`POC_SEL_LSB];
  assign wr_mtrig = io_wr && (io_addr == `POC_ADDR_MASTER_TRIG);
  assign wr_strig = io_wr && (io_addr == `POC_ADDR_SLAVE_TRIG);
  assign rd_mtrig = io_rd && (io_addr == `POC_ADDR_MASTER_TRIG);
  assign rd_strig = io_rd && (io_addr == `POC_ADDR_SLAVE_TRIG);

  // ==========================================================
  // Request recognition
  logic [15:0] clear_vec;
  logic [1:0] ack_r;
  logic [5:0] plevel_r;

  assign clear_vec[7:0] = pending_clear[7:0] | ({8{ack_r[0]}} & (8'h01 << plevel_r[2:0]));
  assign clear_vec[15:8] = pending_clear[15:8] | ({8{ack_r[1]}} & (8'h01 << plevel_r[5:3]));

  poc_trig_detect u_master_detect (
    .clk(clk),
    .resetn(resetn),
    .irq_in(irq_in[7:0]),
    .trigger_mode(master_trigger_mode),
    .clear(clear_vec[7:0]),
    .pending_requests(pending_requests[7:0])
  );

  poc_trig_detect u_slave_detect (
    .clk(clk),
    .resetn(resetn),
    .irq_in(irq_in[15:8]),
    .trigger_mode(slave_trigger_mode),
    .clear(clear_vec[15:8]),
    .pending_requests(pending_requests[15:8])
  );

  // ==========================================================
  // Control state
  poc_pkg::poc_rsel_e sel_r [2];
  poc_pkg::poc_rsel_e sel_nxt [2];
  logic [1:0] mask_mode_nxt;
  logic [1:0] poll_r;
  logic [1:0] poll_nxt;
  logic [1:0] ack_nxt;
  logic [1:0] word_two_nxt;
  logic [5:0] plevel_nxt;
  poc_pkg::poc_byte_t rdata_nxt;
  poc_pkg::poc_byte_t mtrig_nxt;
  poc_pkg::poc_byte_t strig_nxt;
  logic [3:0] pick [2];

  always_comb begin
    mask_mode_nxt = special_masking_mode;
    poll_nxt = poll_r;
    ack_nxt = 2'h0;
    word_two_nxt = 2'h0;
    plevel_nxt = plevel_r;
    rdata_nxt = `POC_RDATA_IDLE;
    mtrig_nxt = master_trigger_mode;
    strig_nxt = slave_trigger_mode;
    for (int c = 0; c < 2; c++) begin
      sel_nxt[c] = sel_r[c];
      pick[c] = poll_pick(pending_requests[c*8 +: 8], mask_in[c*8 +: 8],
                          in_service_levels[c*8 +: 8], special_masking_mode[c]);
      if (init_done[c]) begin
        sel_nxt[c] = poc_pkg::POC_READ_PENDING;
      end
      // A read and a new poll command in one cycle: the read consumes the old poll.
      if (rd_cmd[c]) begin
        if (poll_r[c]) begin
          rdata_nxt = {pick[c][3], 4'h0, pick[c][2:0]};
          poll_nxt[c] = 1'b0;
          ack_nxt[c] = pick[c][3];
          plevel_nxt[c*3 +: 3] = pick[c][2:0];
        end else if (sel_r[c] == poc_pkg::POC_READ_IN_SERVICE) begin
          rdata_nxt = in_service_levels[c*8 +: 8];
        end else begin
          rdata_nxt = pending_requests[c*8 +: 8];
        end
      end
      if (wr_cmd[c] && sel_field == `POC_SEL_WORD_THREE) begin
        if (io_wdata[`POC_BIT_MASK_MODE_WE]) begin
          mask_mode_nxt[c] = io_wdata[`POC_BIT_MASK_MODE];
        end
        poll_nxt[c] = io_wdata[`POC_BIT_POLL];
        if (io_wdata[`POC_BIT_RR]) begin
          sel_nxt[c] = io_wdata[`POC_BIT_RIS] ? poc_pkg::POC_READ_IN_SERVICE
                                               : poc_pkg::POC_READ_PENDING;
        end
      end
      if (wr_cmd[c] && sel_field == `POC_SEL_WORD_TWO) begin
        word_two_nxt[c] = 1'b1;
      end
    end
    if (wr_mtrig) begin
      mtrig_nxt = io_wdata & `POC_MASTER_TRIG_WMASK;
    end
    if (wr_strig) begin
      strig_nxt = io_wdata & `POC_SLAVE_TRIG_WMASK;
    end
    if (rd_mtrig) begin
      rdata_nxt = master_trigger_mode;
    end
    if (rd_strig) begin
      rdata_nxt = slave_trigger_mode;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_r[0] <= poc_pkg::POC_READ_PENDING;
      sel_r[1] <= poc_pkg::POC_READ_PENDING;
      special_masking_mode <= 2'h0;
      poll_r <= 2'h0;
      ack_r <= 2'h0;
      plevel_r <= 6'h00;
      op_control_word_two_wr <= 2'h0;
      io_rdata <= `POC_RDATA_IDLE;
      master_trigger_mode <= `POC_TRIG_RESET;
      slave_trigger_mode <= `POC_TRIG_RESET;
    end else begin
      sel_r[0] <= sel_nxt[0];
      sel_r[1] <= sel_nxt[1];
      special_masking_mode <= mask_mode_nxt;
      poll_r <= poll_nxt;
      ack_r <= ack_nxt;
      plevel_r <= plevel_nxt;
      op_control_word_two_wr <= word_two_nxt;
      io_rdata <= rdata_nxt;
      master_trigger_mode <= mtrig_nxt;
      slave_trigger_mode <= strig_nxt;
    end
  end

  assign poll_ack = ack_r;
  assign poll_level = plevel_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_other_word_ignored: assert property (
    (wr_cmd[0] && sel_field != `POC_SEL_WORD_THREE && !rd_cmd[0])
      |=> $stable(special_masking_mode[0]) && $stable(poll_r[0]))
    else $error("Non word-three write changed word-three state.");

  a_word_two_flag: assert property (
    (wr_cmd[1] && sel_field == `POC_SEL_WORD_TWO) |=> op_control_word_two_wr[1] ##1
      !op_control_word_two_wr[1] || $past(wr_cmd[1]))
    else $error("Word-two write not flagged for one cycle.");

  a_mask_mode_hold: assert property (
    (wr_cmd[0] && sel_field == `POC_SEL_WORD_THREE && !io_wdata[`POC_BIT_MASK_MODE_WE])
      |=> $stable(special_masking_mode[0]))
    else $error("Special masking changed without enable bit.");

  a_mask_mode_apply: assert property (
    (wr_cmd[1] && sel_field == `POC_SEL_WORD_THREE && io_wdata[`POC_BIT_MASK_MODE_WE])
      |=> special_masking_mode[1] == $past(io_wdata[`POC_BIT_MASK_MODE]))
    else $error("Special masking not taken from bit 6.");

  a_poll_answer: assert property (
    (rd_cmd[0] && poll_r[0] && !wr_cmd[0])
      |=> !poll_r[0] && io_rdata[`POC_POLL_VALID] == poll_ack[0]
      && io_rdata[6:3] == 4'h0 && io_rdata[2:0] == poll_level[2:0])
    else $error("Polled read did not answer and disarm.");

  a_poll_code: assert property (
    (rd_cmd[0] && poll_r[0] && special_masking_mode[0] && mask_in[0] == 1'b0
      && pending_requests[0]) |=> io_rdata == 8'h80)
    else $error("Polled read missed top requesting level.");

  a_select_hold: assert property (
    !(wr_cmd[0] && sel_field == `POC_SEL_WORD_THREE && io_wdata[`POC_BIT_RR])
      && !init_done[0] |=> sel_r[0] == $past(sel_r[0]))
    else $error("Readback selection changed without a write.");

  a_init_pending: assert property (
    (init_done[1] && !wr_cmd[1]) |=> sel_r[1] == poc_pkg::POC_READ_PENDING)
    else $error("Initialization did not select pending readback.");

  a_in_service_read: assert property (
    (rd_cmd[1] && !poll_r[1] && sel_r[1] == poc_pkg::POC_READ_IN_SERVICE)
      |=> io_rdata == $past(in_service_levels[15:8]))
    else $error("In-service readback returned wrong byte.");

  a_trig_reserved: assert property (
    master_trigger_mode[2:0] == 3'h0 && slave_trigger_mode[5] == 1'b0
      && slave_trigger_mode[0] == 1'b0)
    else $error("Reserved trigger bit is set.");

  a_trig_write: assert property (
    wr_mtrig |=> master_trigger_mode == ($past(io_wdata) & `POC_MASTER_TRIG_WMASK))
    else $error("Master trigger register write lost.");

  c_poll_read: cover property (rd_cmd[0] && poll_r[0] ##1 poll_ack[0]);
  c_mask_mode_set: cover property ($rose(special_masking_mode[1]));
  c_level_slave: cover property (wr_strig ##1 slave_trigger_mode != 8'h00);

endmodule

/* File: src/poc_trig_detect.sv */
// Request recognition for one controller: edge or level per channel into a pending register.
`timescale 1ns/1ps
`include "poc_defs.svh"

module poc_trig_detect (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] irq_in,
  input wire logic [7:0] trigger_mode,
  input wire logic [7:0] clear,
  output logic [7:0] pending_requests
);

  // ==========================================================
  // Recognition
  logic [7:0] prev_r;
  logic [7:0] prev_nxt;
  logic [7:0] pend_nxt;

  assign prev_nxt = irq_in;

  // A fresh edge beats a clear in the same cycle, so no request is lost.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_chan
      assign pend_nxt[gi] = trigger_mode[gi] ? irq_in[gi] :
        ((irq_in[gi] & ~prev_r[gi]) | (pending_requests[gi] & ~clear[gi]));
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 8'h00;
      pending_requests <= 8'h00;
    end else begin
      prev_r <= prev_nxt;
      pending_requests <= pend_nxt;
    end
  end

  // ==========================================================
  // Checks
  a_edge_only_rise: assert property (@(posedge clk) disable iff (!resetn)
    ((pending_requests & ~$past(pending_requests) & ~$past(trigger_mode))
      & ~($past(irq_in) & ~$past(prev_r))) == 8'h00)
    else $error("Edge channel became pending without a rising input.");

  a_level_follow: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> ((pending_requests ^ $past(irq_in)) & $past(trigger_mode)) == 8'h00)
    else $error("Level channel does not follow its input.");

endmodule

/* File: verification/poc_host_model.sv */
// Host side model that issues byte reads and writes on the I/O strobes.
`timescale 1ns/1ps

module poc_host_model (
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // ==========================================================
  // Idle bus
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // ==========================================================
  // Accesses
  // Released lines are inverted so a stale value is never mistaken for a live one.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = (a[15:8] == 8'h00) ? {1'b0, d[6:0]} : d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~io_wdata;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for control word decode, status readback, poll and trigger modes.
`timescale 1ns/1ps
`include "poc_defs.svh"

module testbench;
  localparam logic [15:0] mc = `POC_ADDR_MASTER_CMD;
  localparam logic [15:0] sc = `POC_ADDR_SLAVE_CMD;
  localparam logic [15:0] mt = `POC_ADDR_MASTER_TRIG;
  localparam logic [15:0] st = `POC_ADDR_SLAVE_TRIG;
  logic clk;
  logic resetn;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [15:0] irq_in;
  logic [15:0] isl;
  logic [15:0] pending_clear;
  logic [15:0] msk;
  logic [1:0] init_done;
  logic [7:0] io_rdata;
  logic [15:0] pend;
  logic [7:0] mtm;
  logic [7:0] stm;
  logic [1:0] mask_mode;
  logic [1:0] w2;
  logic [1:0] pack;
  logic [5:0] plvl;
  logic [7:0] d;
  int fails;
  int check_count;

  poc_host_model host (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));

  poc_ctrl dut (.clk(clk), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .irq_in(irq_in), .in_service_levels(isl), .mask_in(msk),
    .pending_clear(pending_clear), .init_done(init_done), .io_rdata(io_rdata),
    .pending_requests(pend), .master_trigger_mode(mtm), .slave_trigger_mode(stm),
    .special_masking_mode(mask_mode), .op_control_word_two_wr(w2), .poll_ack(pack),
    .poll_level(plvl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // Checking
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    host.rd(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(40 * 3000);
    fails++;
    end_of_test();
  end

  // ==========================================================
  // Tests
  initial begin
    resetn = 1'b0;
    irq_in = 16'h0000;
    isl = 16'h2404;
    pending_clear = 16'h0000;
    msk = 16'h0000;
    init_done = 2'b00;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    rdc(mt, 8'h00);
    rdc(st, 8'h00);
    rdc(16'h04d2, 8'h00);
    rdc(mc, 8'h00);
    $display("test reset done");
    host.wr(mt, 8'hff);
    host.wr(st, 8'hff);
    rdc(mt, 8'hf8);
    rdc(st, 8'hde);
    check({8'h00, mtm}, 16'h00f8);
    check({8'h00, stm}, 16'h00de);
    irq_in = 16'h2019;
    settle(3);
    check(pend, 16'h2019);
    irq_in = 16'h0000;
    settle(3);
    check(pend, 16'h2001);
    pending_clear = 16'h2001;
    settle(1);
    pending_clear = 16'h0000;
    settle(2);
    check(pend, 16'h0000);
    host.wr(mt, 8'h00);
    irq_in = 16'h0010;
    settle(3);
    irq_in = 16'h0000;
    settle(3);
    check(pend, 16'h0010);
    $display("test trigger done");
    host.wr(mc, 8'h0b);
    rdc(mc, 8'h04);
    rdc(mc, 8'h04);
    host.wr(sc, 8'h0b);
    rdc(sc, 8'h24);
    host.wr(mc, 8'h09);
    rdc(mc, 8'h04);
    host.wr(mc, 8'h02);
    check({14'h0000, w2}, 16'h0001);
    host.wr(mc, 8'h12);
    rdc(mc, 8'h04);
    host.wr(mc, 8'h0a);
    rdc(mc, 8'h10);
    host.wr(mc, 8'h0b);
    @(posedge clk);
    #1;
    init_done = 2'b11;
    settle(1);
    init_done = 2'b00;
    rdc(mc, 8'h10);
    rdc(sc, 8'h00);
    $display("test status done");
    host.wr(mc, 8'h48);
    check({14'h0000, mask_mode}, 16'h0000);
    host.wr(mc, 8'h0c);
    rdc(mc, 8'h00);
    host.wr(mc, 8'h68);
    check({14'h0000, mask_mode}, 16'h0001);
    host.wr(mc, 8'h0c);
    host.rd(mc, d);
    check({8'h00, d}, 16'h0084);
    check({14'h0000, pack}, 16'h0001);
    check({13'h0000, plvl[2:0]}, 16'h0004);
    rdc(mc, 8'h00);
    check(pend, 16'h0000);
    msk = 16'h0001;
    irq_in = 16'h0011;
    settle(2);
    irq_in = 16'h0000;
    host.wr(mc, 8'h0c);
    rdc(mc, 8'h84);
    msk = 16'h0000;
    host.wr(mc, 8'h0c);
    rdc(mc, 8'h80);
    host.wr(mc, 8'h28);
    check({14'h0000, mask_mode}, 16'h0000);
    $display("test poll done");
    host.wr(sc, 8'h68);
    check({14'h0000, mask_mode}, 16'h0002);
    host.wr(sc, 8'h02);
    check({14'h0000, w2}, 16'h0002);
    check({14'h0000, mask_mode}, 16'h0002);
    $display("test slave done");
    end_of_test();
  end
endmodule
